// ---- include/led_mode_params.svh ----
// Offsets, bit positions, reset values and timing counts of the mode block
`ifndef LED_MODE_PARAMS_SVH
`define LED_MODE_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_MODE 8'h01
`define ADDR_EVENT 8'h02
`define ADDR_IRQ_EN 8'h03
`define ADDR_CONFIG 8'h04

// ----------------------------------------
// Mode register bit positions
// ----------------------------------------
`define MODE_BACKLIGHT_ON 0
`define MODE_AUTO_FOLLOW 1
`define MODE_SYNC_SINK 2
`define MODE_GAIN_BLOCK 3
`define MODE_DIM_ACTIVE 4
`define MODE_ACTIVE 5
`define MODE_IRQ_PULSE 6

// ----------------------------------------
// Event and enable bit positions, masks
// ----------------------------------------
`define EV_MAIN 0
`define EV_SECOND 1
`define EV_OVERVOLT 2
`define EV_OVERTEMP 3
`define EV_SHORT 4
`define EV_COUNT 5
`define EVENT_MASK 8'h1F
`define LEVEL_LSB 3
`define RESET_BYTE 8'h00

// ----------------------------------------
// Brightness level codes
// ----------------------------------------
`define LEVEL_DAYLIGHT 2'h0
`define LEVEL_OFFICE 2'h1
`define LEVEL_DARK 2'h2

// ----------------------------------------
// Pin synchroniser lanes
// ----------------------------------------
`define SYNC_WIDTH 7
`define LANE_OFFICE 5
`define LANE_DARK 6
`define SINK_COUNT 7

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_FREQ_MHZ 50
`define IRQ_RELEASE_US 50
`define IRQ_RELEASE_CYC (`IRQ_RELEASE_US * `CLK_FREQ_MHZ)
`define RELEASE_CNT_W 12

`endif

// ---- include/led_mode_pkg.sv ----
// Types shared by the mode and event register block
package led_mode_pkg;
`include "led_mode_params.svh"

    typedef enum logic [1:0] {GAIN_1X, GAIN_1P5X, GAIN_2X} gain_t;

    typedef enum logic [1:0] {IRQ_QUIET, IRQ_ASSERT, IRQ_RELEASE} irq_state_t;

    typedef struct packed {
        logic irq_pulse;
        logic active;
        logic dim_active;
        logic gain_down_block;
        logic sync_sink_enable;
        logic auto_level_follow;
        logic backlight_on;
        logic [`EV_COUNT-1:0] irq_enable;
        logic [1:0] brightness_level;
        logic sink_group_on;
        gain_t gain;
        irq_state_t irq_state;
        logic [`RELEASE_CNT_W-1:0] release_cnt;
        logic [7:0] rdata;
    } regs_state_t;

    typedef struct packed {
        logic [`SYNC_WIDTH-1:0] first;
        logic [`SYNC_WIDTH-1:0] stable;
    } sync_state_t;

    typedef struct packed {
        logic primed;
        logic prev;
        logic flag;
    } flag_state_t;

endpackage

// ---- rtl/pin_sync.sv ----
// Two-flop synchroniser for the analog status pins
`timescale 1ns/1ns
`include "led_mode_params.svh"
module pin_sync
    import led_mode_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [`SYNC_WIDTH-1:0] pins,
    output logic [`SYNC_WIDTH-1:0] synced
);
    sync_state_t state;
    sync_state_t next_state;

    // First stage feeds only the second stage
    always_comb begin
        next_state.first = pins;
        next_state.stable = state.first;
    end

    // Register the copy
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign synced = state.stable;
endmodule

// ---- rtl/event_flag.sv ----
// One sticky event flag with write-one-to-clear
`timescale 1ns/1ns
module event_flag
    import led_mode_pkg::*;
#(
    parameter bit ANY_EDGE = 1'b0
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic sample,
    input wire logic clear,
    output logic flag
);
    flag_state_t state;
    flag_state_t next_state;
    logic hit;

    // Level faults latch while high; light sensor inputs latch on any change
    always_comb begin
        if (ANY_EDGE) begin
            hit = state.primed && (sample != state.prev);
        end else begin
            hit = sample;
        end
        next_state.primed = 1'b1;
        next_state.prev = sample;
        // Set wins over a clear in the same cycle
        if (hit) begin
            next_state.flag = 1'b1;
        end else if (clear) begin
            next_state.flag = 1'b0;
        end else begin
            next_state.flag = state.flag;
        end
    end

    // Register the copy
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign flag = state.flag;
endmodule

// ---- rtl/led_mode_regs.sv ----
// Mode control, event flags and interrupt logic of the LED driver
`timescale 1ns/1ns
`include "led_mode_params.svh"
module led_mode_regs
    import led_mode_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic short_fault,
    input wire logic overtemp_fault,
    input wire logic overvoltage_fault,
    input wire logic main_light_sensor_input,
    input wire logic second_light_sensor_input,
    input wire logic office_level_comparator_out,
    input wire logic dark_level_comparator_out,
    input wire logic office_level_comparator_enable,
    input wire logic dark_level_comparator_enable,
    input wire logic dim_timeout,
    input wire logic [`SINK_COUNT-1:0] per_channel_sink_enable,
    input wire logic [`SINK_COUNT-1:0] independent_sink,
    input wire logic gain_up_request,
    input wire logic gain_down_request,
    input wire logic all_leds_off,
    output logic device_active,
    output logic backlight_enable,
    output logic dim_mode,
    output logic [1:0] brightness_level,
    output logic [`SINK_COUNT-1:0] sync_sinks_on,
    output led_mode_pkg::gain_t pump_gain,
    output logic irq_n
);
    import led_mode_pkg::*;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    regs_state_t state;
    regs_state_t next_state;
    logic [`SYNC_WIDTH-1:0] raw_pins;
    logic [`SYNC_WIDTH-1:0] synced;
    logic [`EV_COUNT-1:0] flags;
    logic [`EV_COUNT-1:0] flag_clear;
    logic wr_mode;
    logic wr_event;
    logic wr_irq_en;
    logic wr_config;
    logic clear_attempt;
    logic pending;
    logic pending_after_clear;
    logic any_channel_enable;
    logic level_follow;
    logic [1:0] followed_level;
    logic release_done;

    // ----------------------------------------
    // Pin synchronisers and event flags
    // ----------------------------------------

    // Gather all asynchronous status pins into one synchroniser
    assign raw_pins = {dark_level_comparator_out,
                       office_level_comparator_out,
                       short_fault,
                       overtemp_fault,
                       overvoltage_fault,
                       second_light_sensor_input,
                       main_light_sensor_input};

    pin_sync u_pin_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .pins(raw_pins),
        .synced(synced)
    );

    // Clear strobes for the flags, one per written 1
    assign flag_clear = wr_event ? reg_wdata[`EV_COUNT-1:0]
                                 : {`EV_COUNT{1'b0}};

    // Light sensor flags catch any change, fault flags latch a level
    genvar gi;
    generate
        for (gi = 0; gi < `EV_COUNT; gi = gi + 1) begin : g_flag
            event_flag #(
                .ANY_EDGE(gi <= `EV_SECOND)
            ) u_flag (
                .clk(clk),
                .sys_rst(sys_rst),
                .sample(synced[gi]),
                .clear(flag_clear[gi]),
                .flag(flags[gi])
            );
        end
    endgenerate

    // ----------------------------------------
    // Register decode
    // ----------------------------------------

    // Write strobes per register
    always_comb begin
        wr_mode = reg_wr && (reg_addr == `ADDR_MODE);
        wr_event = reg_wr && (reg_addr == `ADDR_EVENT);
        wr_irq_en = reg_wr && (reg_addr == `ADDR_IRQ_EN);
        wr_config = reg_wr && (reg_addr == `ADDR_CONFIG);
    end

    // A clear attempt is any write of a 1 to a flag position
    assign clear_attempt = wr_event && |(reg_wdata & `EVENT_MASK);

    // Enabled pending events, now and after the clear takes effect
    assign pending = |(flags & state.irq_enable);
    assign pending_after_clear =
        |(flags & state.irq_enable & ~flag_clear);

    // Channel enables veto the synchronous sink bit
    assign any_channel_enable = |per_channel_sink_enable;

    // Level follows comparators only with at least one level enabled
    assign level_follow = state.auto_level_follow &&
        (office_level_comparator_enable ||
         dark_level_comparator_enable);

    // Darkest enabled comparator wins
    always_comb begin
        if (dark_level_comparator_enable && synced[`LANE_DARK]) begin
            followed_level = `LEVEL_DARK;
        end else if (office_level_comparator_enable &&
                     synced[`LANE_OFFICE]) begin
            followed_level = `LEVEL_OFFICE;
        end else begin
            followed_level = `LEVEL_DAYLIGHT;
        end
    end

    // Release window ends after the full count
    assign release_done = (state.release_cnt ==
        `RELEASE_CNT_W'(`IRQ_RELEASE_CYC - 1));

    // ----------------------------------------
    // Next state
    // ----------------------------------------

    // Register writes, hardware updates and interrupt sequencing
    always_comb begin
        next_state = state;

        // Mode register, reserved bit 7 dropped
        if (wr_mode) begin
            next_state.irq_pulse = reg_wdata[`MODE_IRQ_PULSE];
            next_state.active = reg_wdata[`MODE_ACTIVE];
            next_state.dim_active = reg_wdata[`MODE_DIM_ACTIVE];
            next_state.gain_down_block =
                reg_wdata[`MODE_GAIN_BLOCK];
            next_state.sync_sink_enable =
                reg_wdata[`MODE_SYNC_SINK];
            next_state.auto_level_follow =
                reg_wdata[`MODE_AUTO_FOLLOW];
            next_state.backlight_on =
                reg_wdata[`MODE_BACKLIGHT_ON];
            // Group follows the bit only with every channel enable low
            if (!any_channel_enable) begin
                next_state.sink_group_on =
                    reg_wdata[`MODE_SYNC_SINK];
            end
        end

        // Hardware sets dim on timeout while backlight is on, winning over a host write
        if (dim_timeout && state.backlight_on) begin
            next_state.dim_active = 1'b1;
        end

        // Interrupt enables, reserved bits dropped
        if (wr_irq_en) begin
            next_state.irq_enable =
                reg_wdata[`EV_COUNT-1:0];
        end

        // Brightness level: host writes it unless comparators drive it
        if (level_follow) begin
            next_state.brightness_level = followed_level;
        end else if (wr_config) begin
            next_state.brightness_level =
                reg_wdata[`LEVEL_LSB+1:`LEVEL_LSB];
        end

        // Pump gain steps; standby parks it at the lowest gain
        if (!state.active) begin
            next_state.gain = GAIN_1X;
        end else if (gain_up_request) begin
            unique case (state.gain)
                GAIN_1X: next_state.gain = GAIN_1P5X;
                GAIN_1P5X: next_state.gain = GAIN_2X;
                GAIN_2X: next_state.gain = GAIN_2X;
                default: next_state.gain = GAIN_1X;
            endcase
        end else if (gain_down_request &&
                     (!state.gain_down_block || all_leds_off)) begin
            unique case (state.gain)
                GAIN_1X: next_state.gain = GAIN_1X;
                GAIN_1P5X: next_state.gain = GAIN_1X;
                GAIN_2X: next_state.gain = GAIN_1P5X;
                default: next_state.gain = GAIN_1X;
            endcase
        end

        // Interrupt sequencer
        next_state.release_cnt = '0;
        unique case (state.irq_state)
            IRQ_QUIET: begin
                if (pending) begin
                    next_state.irq_state = IRQ_ASSERT;
                end
            end
            IRQ_ASSERT: begin
                if (clear_attempt && state.irq_pulse &&
                    pending_after_clear) begin
                    next_state.irq_state = IRQ_RELEASE;
                end else if (!pending) begin
                    next_state.irq_state = IRQ_QUIET;
                end
                // Otherwise it simply holds asserted
            end
            IRQ_RELEASE: begin
                if (release_done) begin
                    next_state.irq_state =
                        pending ? IRQ_ASSERT : IRQ_QUIET;
                end else begin
                    next_state.release_cnt =
                        state.release_cnt + 1'b1;
                end
            end
            default: next_state.irq_state = IRQ_QUIET;
        endcase

        // Read data, captured on a read strobe
        if (reg_rd) begin
            unique case (reg_addr)
                `ADDR_MODE: begin
                    next_state.rdata = {1'b0,
                        state.irq_pulse,
                        state.active,
                        state.dim_active,
                        state.gain_down_block,
                        state.sync_sink_enable,
                        state.auto_level_follow,
                        state.backlight_on};
                end
                `ADDR_EVENT: begin
                    next_state.rdata =
                        8'(flags) & `EVENT_MASK;
                end
                `ADDR_IRQ_EN: begin
                    next_state.rdata = 8'(state.irq_enable);
                end
                `ADDR_CONFIG: begin
                    next_state.rdata =
                        8'(state.brightness_level) << `LEVEL_LSB;
                end
                default: next_state.rdata = `RESET_BYTE;
            endcase
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------

    // Everything returns to zero on reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------

    // Standby gates backlight, dim and sync sinks and parks gain at GAIN_1X; level and interrupt are not gated
    assign device_active = state.active;
    assign backlight_enable =
        state.active && state.backlight_on;
    assign dim_mode = state.active && state.backlight_on &&
        state.dim_active;
    assign brightness_level = state.brightness_level;
    assign sync_sinks_on = (state.active && state.sink_group_on)
        ? independent_sink : {`SINK_COUNT{1'b0}};
    assign pump_gain = state.gain;
    assign reg_rdata = state.rdata;
    // Active low interrupt, held low only in the asserted state
    assign irq_n = (state.irq_state != IRQ_ASSERT);

endmodule

// ---- test/led_mode_regs_monitor.sv ----
// Port checker of the mode and event register block
`timescale 1ns/1ns
`include "led_mode_params.svh"
module led_mode_regs_monitor
    import led_mode_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic [7:0] reg_rdata,
    input wire logic short_fault,
    input wire logic main_light_sensor_input,
    input wire logic dark_level_comparator_out,
    input wire logic dark_level_comparator_enable,
    input wire logic dim_timeout,
    input wire logic [`SINK_COUNT-1:0] per_channel_sink_enable,
    input wire logic [`SINK_COUNT-1:0] independent_sink,
    input wire logic all_leds_off,
    input wire logic device_active,
    input wire logic backlight_enable,
    input wire logic dim_mode,
    input wire logic [1:0] brightness_level,
    input wire logic [`SINK_COUNT-1:0] sync_sinks_on,
    input wire led_mode_pkg::gain_t pump_gain,
    input wire logic irq_n
);
    logic [6:0] mode_sh;
    logic [4:0] en_sh;
    logic [11:0] rel_cnt;
    wire wr_mode = reg_wr && reg_addr == `ADDR_MODE;
    wire clr_try = reg_wr && reg_addr == `ADDR_EVENT &&
        reg_wdata[4:0] != 5'h00;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // Mirror of written mode and enable bits, release window count
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode_sh <= 7'h00;
            en_sh <= 5'h00;
            rel_cnt <= 12'h000;
        end else begin
            if (wr_mode) begin
                mode_sh <= reg_wdata[6:0];
            end
            if (reg_wr && reg_addr == `ADDR_IRQ_EN) begin
                en_sh <= reg_wdata[4:0];
            end
            if (rel_cnt == 12'h9C4) begin
                rel_cnt <= 12'h000; // Window of 2500 cycles over
            end else if (rel_cnt != 12'h000) begin
                rel_cnt <= rel_cnt + 12'h001;
            end else if (clr_try && mode_sh[6] && !irq_n) begin
                rel_cnt <= 12'h001;
            end
        end
    end

    property p_reset;
        disable iff (1'b0) sys_rst |=> irq_n && reg_rdata == 8'h00 &&
            !device_active;
    endproperty
    a_reset: assert property (p_reset)
        else $error("outputs not cleared by reset");
    property p_standby;
        !device_active |-> !backlight_enable && !dim_mode &&
            sync_sinks_on == 7'h00;
    endproperty
    a_standby: assert property (p_standby)
        else $error("function alive in standby");
    property p_backlight;
        (backlight_enable || dim_mode) |-> device_active && backlight_enable;
    endproperty
    a_backlight: assert property (p_backlight)
        else $error("backlight without active mode");
    property p_dim_set;
        dim_timeout && backlight_enable && !wr_mode |=> dim_mode;
    endproperty
    a_dim_set: assert property (p_dim_set)
        else $error("dim timeout did not set dim");
    property p_gain_hold;
        mode_sh[3] && device_active && !all_leds_off && !wr_mode
            |=> pump_gain >= $past(pump_gain);
    endproperty
    a_gain_hold: assert property (p_gain_hold)
        else $error("gain lowered while blocked");
    property p_sync_on;
        wr_mode && reg_wdata[5] && reg_wdata[2] &&
            per_channel_sink_enable == 7'h00
            |=> sync_sinks_on == independent_sink;
    endproperty
    a_sync_on: assert property (p_sync_on)
        else $error("independent sinks not switched on");
    property p_auto;
        (mode_sh[1] && dark_level_comparator_enable &&
            dark_level_comparator_out) [*5]
            |-> brightness_level == `LEVEL_DARK;
    endproperty
    a_auto: assert property (p_auto)
        else $error("level does not follow dark comparator");
    property p_short;
        $rose(short_fault) && en_sh[4] && !mode_sh[6] |-> ##[1:6] !irq_n;
    endproperty
    a_short: assert property (p_short)
        else $error("short fault raised no interrupt");
    property p_main;
        $changed(main_light_sensor_input) && en_sh[0] && !mode_sh[6]
            |-> ##[1:6] !irq_n;
    endproperty
    a_main: assert property (p_main)
        else $error("main sensor change raised no interrupt");
    property p_quiet;
        en_sh == 5'h00 && $past(en_sh, 2) == 5'h00 |-> irq_n;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("interrupt with all events disabled");
    property p_pulse;
        rel_cnt >= 12'h002 |-> irq_n;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("interrupt reasserted inside release window");
endmodule

bind led_mode_regs led_mode_regs_monitor i_mon (.*);

// ---- test/host_model.sv ----
// Host model driving the register strobe port
`timescale 1ns/1ns
module host_model (
    input wire logic clk,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    // Idle port at time zero
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // One write, held until the edge that takes it
    task automatic wr(input logic [7:0] a,
        input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // One read, data taken once it has settled
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        #1;
        d = reg_rdata;
    endtask
endmodule

// ---- test/led_mode_regs_tb.sv ----
// Self-checking bench of the mode and event register block
`timescale 1ns/1ns
`include "led_mode_params.svh"
module led_mode_regs_tb;
    import led_mode_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rdv;
    logic reg_wr, reg_rd, irq_n, device_active, backlight_enable, dim_mode;
    logic short_fault, overtemp_fault, overvoltage_fault, dim_timeout;
    logic main_light_sensor_input, second_light_sensor_input;
    logic office_level_comparator_out, dark_level_comparator_out;
    logic office_level_comparator_enable, dark_level_comparator_enable;
    logic gain_up_request, gain_down_request, all_leds_off;
    logic [`SINK_COUNT-1:0] per_channel_sink_enable, independent_sink;
    logic [`SINK_COUNT-1:0] sync_sinks_on;
    logic [1:0] brightness_level;
    gain_t pump_gain;
    int n_fail = 0;
    int n_checks = 0;

    led_mode_regs i_dut (.*);
    host_model i_host (.*);

    // 50 MHz clock
    always #10 clk = ~clk;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd_chk(string what, logic [7:0] a, logic [7:0] exp);
        i_host.rd(a, rdv);
        check(what, rdv, exp);
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic gain_step(logic up);
        @(posedge clk);
        gain_up_request <= up;
        gain_down_request <= !up;
        @(posedge clk);
        gain_up_request <= 1'b0;
        gain_down_request <= 1'b0;
        tick(1);
    endtask
    task automatic stop_test;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        for (int a = 1; a < 6; a++) begin
            rd_chk("reset reg", 8'(a), 8'h00);
        end
        check("irq_n", irq_n, 16'h1);
        i_host.wr(8'h05, 8'hFF);
        rd_chk("unmapped", 8'h05, 8'h00);
        i_host.wr(`ADDR_IRQ_EN, 8'hE0);
        rd_chk("enable spare", `ADDR_IRQ_EN, 8'h00);
        $display("reset test done");
    endtask
    task automatic t_mode;
        i_host.wr(`ADDR_MODE, 8'hB5);
        tick(0);
        check("backlight", backlight_enable, 16'h1);
        check("dim", dim_mode, 16'h1);
        check("sinks on", sync_sinks_on, 16'h55);
        rd_chk("mode", `ADDR_MODE, 8'h35);
        per_channel_sink_enable <= 7'h01;
        i_host.wr(`ADDR_MODE, 8'h31);
        tick(0);
        check("sinks kept", sync_sinks_on, 16'h55);
        per_channel_sink_enable <= 7'h00;
        i_host.wr(`ADDR_MODE, 8'h31);
        tick(0);
        check("sinks off", sync_sinks_on, 16'h00);
        i_host.wr(`ADDR_MODE, 8'h11);
        tick(0);
        check("standby", {device_active, backlight_enable}, 16'h0);
        i_host.wr(`ADDR_MODE, 8'h30);
        tick(0);
        check("dim no bl", dim_mode, 16'h0);
        $display("mode test done");
    endtask
    task automatic t_dim(logic [7:0] mode, logic [7:0] exp);
        i_host.wr(`ADDR_MODE, mode);
        dim_timeout <= 1'b1;
        @(posedge clk);
        dim_timeout <= 1'b0;
        tick(1);
        rd_chk("dim bit", `ADDR_MODE, exp);
        $display("dim test done");
    endtask
    task automatic t_auto;
        i_host.wr(`ADDR_CONFIG, 8'h08);
        dark_level_comparator_enable <= 1'b1;
        dark_level_comparator_out <= 1'b1;
        tick(5);
        check("manual level", brightness_level, 16'h1);
        i_host.wr(`ADDR_MODE, 8'h22);
        rd_chk("auto level", `ADDR_CONFIG, 8'h10);
        i_host.wr(`ADDR_CONFIG, 8'h00);
        tick(1);
        check("dark level", brightness_level, 16'h2);
        dark_level_comparator_out <= 1'b0;
        office_level_comparator_enable <= 1'b1;
        office_level_comparator_out <= 1'b1;
        tick(5);
        check("office level", brightness_level, 16'h1);
        i_host.wr(`ADDR_MODE, 8'h00);
        $display("auto test done");
    endtask
    task automatic t_gain;
        i_host.wr(`ADDR_MODE, 8'h20);
        gain_step(1'b1);
        gain_step(1'b1);
        check("gain up", pump_gain, GAIN_2X);
        gain_step(1'b0);
        check("gain down", pump_gain, GAIN_1P5X);
        i_host.wr(`ADDR_MODE, 8'h28);
        gain_step(1'b0);
        check("gain held", pump_gain, GAIN_1P5X);
        gain_step(1'b1);
        check("gain raised", pump_gain, GAIN_2X);
        all_leds_off <= 1'b1;
        gain_step(1'b0);
        check("gain freed", pump_gain, GAIN_1P5X);
        $display("gain test done");
    endtask
    task automatic t_flags;
        i_host.wr(`ADDR_IRQ_EN, 8'h10);
        for (int i = 0; i < 5; i++) begin
            case (i)
                0: main_light_sensor_input <= !main_light_sensor_input;
                1: second_light_sensor_input <= !second_light_sensor_input;
                2: overvoltage_fault <= 1'b1;
                3: overtemp_fault <= 1'b1;
                default: short_fault <= 1'b1;
            endcase
            @(posedge clk);
            {short_fault, overtemp_fault, overvoltage_fault} <= 3'h0;
            tick(5);
            rd_chk("flag", `ADDR_EVENT, 8'h01 << i);
            check("irq_n", irq_n, 16'(i != 4));
            i_host.wr(`ADDR_EVENT, ~(8'h01 << i));
            rd_chk("flag kept", `ADDR_EVENT, 8'h01 << i);
            i_host.wr(`ADDR_EVENT, 8'h01 << i);
            rd_chk("flag cleared", `ADDR_EVENT, 8'h00);
        end
        $display("flag test done");
    endtask
    task automatic t_irq(logic pulse);
        int n = 0;
        i_host.wr(`ADDR_MODE, {1'b0, pulse, 6'h20});
        i_host.wr(`ADDR_IRQ_EN, 8'h03);
        main_light_sensor_input <= !main_light_sensor_input;
        second_light_sensor_input <= !second_light_sensor_input;
        tick(6);
        check("irq raised", irq_n, 16'h0);
        i_host.wr(`ADDR_EVENT, 8'h01);
        tick(0);
        for (int k = 0; k < 2600; k++) begin
            if (irq_n === 1'b1) begin
                n++;
            end
            tick(1);
        end
        check("release cycles", 16'(n),
            pulse ? 16'd2500 : 16'd0);
        check("irq pending", irq_n, 16'h0);
        i_host.wr(`ADDR_EVENT, 8'h1F);
        tick(3);
        check("irq dropped", irq_n, 16'h1);
        $display("interrupt test done");
    endtask

    // Reset, then every scenario in turn
    initial begin
        {short_fault, overtemp_fault, overvoltage_fault, dim_timeout} = '0;
        {main_light_sensor_input, second_light_sensor_input} = '0;
        {office_level_comparator_out, dark_level_comparator_out} = '0;
        {office_level_comparator_enable, dark_level_comparator_enable} = '0;
        {gain_up_request, gain_down_request, all_leds_off} = '0;
        per_channel_sink_enable = 7'h00;
        independent_sink = 7'h55;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        tick(1);
        t_reset;
        t_mode;
        t_dim(8'h21, 8'h31);
        t_dim(8'h20, 8'h20);
        t_auto;
        t_gain;
        t_flags;
        t_irq(1'b0);
        t_irq(1'b1);
        stop_test;
    end
endmodule
